// ==== core/eec_defs.vh ====
// Purpose: shared constants for the external event counter
// Assumes: included by bare name from core design files
// Notes:   counts are rising count input edges, not clk cycles at 250 MHz
`ifndef EEC_DEFS_VH
`define EEC_DEFS_VH
`define EEC_CNT_WIDTH     24
`define EEC_CNT_MAX       24'hFFFFFF
`define EEC_CNT_RESET     24'h000000
`define EEC_SLAVE_ADDR    7'h32
`define EEC_RST_CMD       3'h2
`define EEC_RST_CMD_LSB   0
`define EEC_FILL_BYTE     8'hFF
`define EEC_BYTE_BITS     4'h8
`define EEC_CNT_BYTES     2'h3
`define EEC_FREE_BYTES    2'h3
`define EEC_PTR_BIT       7
`endif

// ==== core/eec_sync.v ====
// Purpose: three-stage synchroniser for one pin input
// Assumes: input is asynchronous to clk
// Notes:   level changes once stages two and three agree
`timescale 1ns/100ps
module eec_sync #(
    parameter INIT = 1'b0
) (
    input  wire clk,
    input  wire rst,
    input  wire pinIn,
    output reg  level
);
    reg stage1Reg;
    reg stage2Reg;
    reg stage3Reg;

    // chain; stage1 read only by stage2
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1Reg <= INIT;
            stage2Reg <= INIT;
            stage3Reg <= INIT;
            level     <= INIT;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            if (stage2Reg == stage3Reg)
                level <= stage3Reg;
        end
    end
endmodule // eec_sync

// ==== core/eec_bus_cond.v ====
// Purpose: start/stop and clock edge detection on the serial bus
// Assumes: scl and sda already synchronised to clk
// Notes:   outputs are one-cycle pulses
`timescale 1ns/100ps
module eec_bus_cond (
    input  wire clk,
    input  wire rst,
    input  wire sclLvl,
    input  wire sdaLvl,
    output wire startPulse,
    output wire stopPulse,
    output wire sclRise,
    output wire sclFall
);
    reg sclDlyReg;
    reg sdaDlyReg;

    // previous sample of both lines
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclDlyReg <= 1'b1;
            sdaDlyReg <= 1'b1;
        end else begin
            sclDlyReg <= sclLvl;
            sdaDlyReg <= sdaLvl;
        end
    end

    // sda moving while scl high marks conditions
    assign startPulse = sclLvl & sclDlyReg & sdaDlyReg & ~sdaLvl;
    assign stopPulse  = sclLvl & sclDlyReg & ~sdaDlyReg & sdaLvl;
    assign sclRise    = sclLvl & ~sclDlyReg;
    assign sclFall    = ~sclLvl & sclDlyReg;
endmodule // eec_bus_cond

// ==== core/eec_counter.v ====
// Purpose: 24-bit event counter with serial read of the count
// Assumes: count input, reset pin and bus lines asynchronous to clk
// Notes:   free register storage is kept only for read-back
//
// How it works
// - count each rising count input edge
// - counter is 24-bit unsigned, 0 to FFFFFF
// - maximum plus one edge wraps to zero
// - reset pin or reset command clears counter
// - during transaction ignore edges, hold value
// - transaction spans start to following stop
// - low at start, high at stop: one count
// - first wrap drives wrap flag high
// - every wrap inverts the wrap flag
// - reset pin or command forces flag low
// - count readable as three-byte binary register
// - count register cannot be written
// - three bytes sent most significant first
// - low three free bits 010 mean reset
// - hold cleared while reset pin low
// - address 0110010 read returns bytes two-four
// - reads past three bytes return all ones
`timescale 1ns/100ps
`include "eec_defs.vh"
module eec_counter #(
    parameter CW = `EEC_CNT_WIDTH
) (
    input  wire clk,
    input  wire rst,
    input  wire countInput,
    input  wire resetPinN,
    input  wire scl,
    input  wire sdaIn,
    output reg  sdaOut,
    output reg  sdaOe,
    output reg  wrapFlag
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_ADDR = 5'h02;
    localparam [4:0] S_WRDT = 5'h04;
    localparam [4:0] S_RDDT = 5'h08;
    localparam [4:0] S_SKIP = 5'h10;

    wire cntLvl;
    wire rstNLvl;
    wire sclLvl;
    wire sdaLvl;
    wire startPulse;
    wire stopPulse;
    wire sclRise;
    wire sclFall;

    reg [CW-1:0] countReg;
    reg          cntDlyReg;
    reg          busyReg;
    reg          startLvlReg;
    reg          cmdResetReg;
    reg [4:0]    stateReg;
    reg [7:0]    shiftReg;
    reg [3:0]    bitCntReg;
    reg [2:0]    byteCntReg;
    reg          ackPhaseReg;
    reg          readModeReg;
    reg          ptrCountReg;
    reg [23:0]   freeReg;
    reg [23:0]   snapReg;

    wire         cntRise;
    wire         stopBump;
    wire         doReset;
    wire [CW:0]  countInc;
    wire [23:0]  countView;

    eec_sync #(.INIT(1'b0)) uSyncCnt (
        .clk   (clk),
        .rst   (rst),
        .pinIn (countInput),
        .level (cntLvl)
    );
    eec_sync #(.INIT(1'b0)) uSyncRst (
        .clk   (clk),
        .rst   (rst),
        .pinIn (resetPinN),
        .level (rstNLvl)
    );
    eec_sync #(.INIT(1'b1)) uSyncScl (
        .clk   (clk),
        .rst   (rst),
        .pinIn (scl),
        .level (sclLvl)
    );
    eec_sync #(.INIT(1'b1)) uSyncSda (
        .clk   (clk),
        .rst   (rst),
        .pinIn (sdaIn),
        .level (sdaLvl)
    );

    eec_bus_cond uCond (
        .clk        (clk),
        .rst        (rst),
        .sclLvl     (sclLvl),
        .sdaLvl     (sdaLvl),
        .startPulse (startPulse),
        .stopPulse  (stopPulse),
        .sclRise    (sclRise),
        .sclFall    (sclFall)
    );

    // count input edge and pending stop credit
    assign cntRise  = cntLvl & ~cntDlyReg;
    assign stopBump = stopPulse & busyReg & ~startLvlReg & cntLvl;
    assign doReset  = ~rstNLvl | cmdResetReg;
    assign countInc = {1'b0, countReg} + {{CW{1'b0}}, 1'b1};

    // count widened to the three-byte register view
    generate
        if (CW < 24) begin : gNarrow
            assign countView = {{(24 - CW){1'b0}}, countReg};
        end else begin : gFull
            assign countView = countReg[23:0];
        end
    endgenerate

    // transaction window and count level at start
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cntDlyReg   <= 1'b0;
            busyReg     <= 1'b0;
            startLvlReg <= 1'b0;
        end else begin
            cntDlyReg <= cntLvl;
            if (startPulse && !busyReg) begin
                busyReg     <= 1'b1;
                startLvlReg <= cntLvl;
            end else if (stopPulse) begin
                busyReg <= 1'b0;
            end
        end
    end

    // counter and wrap flag; reset has priority
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            countReg <= {CW{1'b0}};
            wrapFlag <= 1'b0;
        end else if (doReset) begin
            countReg <= {CW{1'b0}};
            wrapFlag <= 1'b0;
        end else if ((cntRise && !busyReg) || stopBump) begin
            countReg <= countInc[CW-1:0];
            if (countInc[CW])
                wrapFlag <= ~wrapFlag;
        end
    end

    // serial slave: address, write free register, read count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stateReg    <= S_IDLE;
            shiftReg    <= 8'h00;
            bitCntReg   <= 4'h0;
            byteCntReg  <= 3'h0;
            ackPhaseReg <= 1'b0;
            readModeReg <= 1'b0;
            ptrCountReg <= 1'b1;
            freeReg     <= 24'h000000;
            snapReg     <= 24'h000000;
            cmdResetReg <= 1'b0;
            sdaOut      <= 1'b0;
            sdaOe       <= 1'b0;
        end else begin
            cmdResetReg <= 1'b0;
            if (stopPulse) begin
                stateReg    <= S_IDLE;
                sdaOe       <= 1'b0;
                ptrCountReg <= 1'b1;
            end else if (startPulse) begin
                stateReg    <= S_ADDR;
                bitCntReg   <= 4'h0;
                ackPhaseReg <= 1'b0;
                sdaOe       <= 1'b0;
            end else if (sclRise && !ackPhaseReg) begin
                shiftReg  <= {shiftReg[6:0], sdaLvl};
                bitCntReg <= bitCntReg + 4'h1;
            end else if (sclRise && ackPhaseReg && stateReg == S_RDDT && sdaLvl) begin
                stateReg <= S_SKIP; // host ended read with no ack
            end else if (sclFall) begin
                if (ackPhaseReg) begin
                    ackPhaseReg <= 1'b0;
                    bitCntReg   <= 4'h0;
                    sdaOe       <= 1'b0;
                    if (stateReg == S_RDDT)
                        sdaOe <= ~shiftReg[7];
                end else if (bitCntReg == `EEC_BYTE_BITS) begin
                    ackPhaseReg <= 1'b1;
                    case (stateReg)
                        S_ADDR: begin
                            if (shiftReg[7:1] == `EEC_SLAVE_ADDR) begin
                                sdaOe      <= 1'b1;
                                byteCntReg <= 3'h0;
                                if (shiftReg[0]) begin
                                    stateReg <= S_RDDT;
                                    // freeze the count or free register snapshot, as the pointer selects, for the whole read
                                    snapReg  <= ptrCountReg ? countView : freeReg;
                                    shiftReg <= ptrCountReg ? countView[23:16]
                                                            : freeReg[23:16];
                                end else begin
                                    stateReg <= S_WRDT;
                                end
                            end else begin
                                stateReg <= S_SKIP;
                            end
                        end
                        S_WRDT: begin
                            sdaOe <= 1'b1;
                            if (byteCntReg == 3'h0)
                                ptrCountReg <= shiftReg[`EEC_PTR_BIT];
                            else if (byteCntReg == 3'h1)
                                freeReg[23:16] <= shiftReg;
                            else if (byteCntReg == 3'h2)
                                freeReg[15:8] <= shiftReg;
                            else if (byteCntReg == 3'h3) begin
                                freeReg[7:0] <= shiftReg;
                                if (shiftReg[2:0] == `EEC_RST_CMD)
                                    cmdResetReg <= 1'b1;
                            end
                            if (byteCntReg != 3'h7)
                                byteCntReg <= byteCntReg + 3'h1;
                        end
                        S_RDDT: begin
                            // next byte loaded before host ack
                            sdaOe <= 1'b0; // free sda for host ack
                            if (byteCntReg != 3'h7)
                                byteCntReg <= byteCntReg + 3'h1;
                            if (byteCntReg == 3'h0)
                                shiftReg <= snapReg[15:8];
                            else if (byteCntReg == 3'h1)
                                shiftReg <= snapReg[7:0];
                            else
                                shiftReg <= `EEC_FILL_BYTE;
                        end
                        default: stateReg <= S_SKIP;
                    endcase
                end else if (stateReg == S_RDDT) begin
                    // rise has shifted, next bit stands at the top
                    sdaOe <= ~shiftReg[7];
                end
            end
        end
    end
endmodule // eec_counter

// ==== verif/eec_counter_properties.sv ====
// Purpose: port checks of eec_counter
// Assumes: scl half period 8 clk, count pulses 8 clk high
// Notes:   bound to every eec_counter
`timescale 1ns/100ps
module eec_counter_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic countInput,
    input wire logic resetPinN,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic wrapFlag
);
    // all checks on clk, off in reset
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_pinClr; !resetPinN [*8] |-> !wrapFlag; endproperty
    a_pinClr: assert property (p_pinClr) else $error("flag high in pin reset");
    property p_init; $fell(rst) |-> !wrapFlag && !sdaOe; endproperty
    a_init: assert property (p_init) else $error("outputs set after reset");
    property p_rise; $rose(wrapFlag) |-> resetPinN && $past(countInput, 2); endproperty
    a_rise: assert property (p_rise) else $error("flag rose without edge");
    property p_quiet; !countInput [*8] |-> !$rose(wrapFlag); endproperty
    a_quiet: assert property (p_quiet) else $error("flag rose with input low");
    property p_od; sdaOut == 1'b0; endproperty
    a_od: assert property (p_od) else $error("sda driven high");
    property p_oeRise; $rose(sdaOe) |-> !scl && !$past(scl, 3); endproperty
    a_oeRise: assert property (p_oeRise) else $error("sda pulled off low scl");
    property p_oeFall; $fell(sdaOe) |-> !scl; endproperty
    a_oeFall: assert property (p_oeFall) else $error("sda freed with scl high");
    property p_oeHold; $rose(scl) |-> $stable(sdaOe) [*6]; endproperty
    a_oeHold: assert property (p_oeHold) else $error("sda moved in scl high");
endmodule // eec_counter_properties

bind eec_counter eec_counter_properties eec_counter_properties_inst (
    .clk(clk), .rst(rst), .countInput(countInput), .resetPinN(resetPinN), .scl(scl),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .wrapFlag(wrapFlag));

// ==== verif/eec_i2c_master.sv ====
// Purpose: serial bus master model
// Assumes: open-drain wire resolved in the bench
// Notes:   64 ns bit period
`timescale 1ns/100ps
module eec_i2c_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaPull
);
    // idle bus
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // wait n clocks, step off the edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one bit out, one sampled with scl high
    task automatic bitx(input logic o, output logic i);
        sdaPull = !o;
        tk(4);
        scl = 1'b1;
        tk(4);
        i = sda;
        tk(4);
        scl = 1'b0;
        tk(4);
    endtask
    // start for s=1, stop for s=0
    task automatic cond(input logic s);
        sdaPull = !s;
        tk(4);
        scl = 1'b1;
        tk(4);
        sdaPull = s;
        tk(4);
        scl = !s;
        tk(4);
    endtask
    // byte msb first, then ack bit
    task automatic byx(input logic [7:0] o, input logic ak, output logic [7:0] r,
                       output logic na);
        for (int k = 7; k >= 0; k--)
            bitx(o[k], r[k]);
        bitx(ak, na);
    endtask
    // address read, three count bytes and one more
    task automatic rdCnt(output logic [31:0] v, output logic na);
        logic [7:0] r;
        logic       a;
        cond(1'b1);
        byx({7'h32, 1'b1}, 1'b1, r, na);
        for (int b = 3; b >= 0; b--) begin
            byx(8'hFF, b == 0, r, a);
            v[b*8 +: 8] = r;
        end
        cond(1'b0);
    endtask
    // address write, pointer byte, three free bytes
    task automatic wrFree(input logic [23:0] f, output logic na);
        logic [7:0] r;
        logic       a;
        cond(1'b1);
        byx({7'h32, 1'b0}, 1'b1, r, na);
        byx(8'h81, 1'b1, r, a);
        na = na | a;
        for (int b = 2; b >= 0; b--) begin
            byx(f[b*8 +: 8], 1'b1, r, a);
            na = na | a;
        end
        cond(1'b0);
    endtask
endmodule // eec_i2c_master

// ==== verif/eec_counter_bench.sv ====
// Purpose: self-checking bench of eec_counter
// Assumes: count seen only over the serial bus
// Notes:   counter built 4 bits wide so wraps are reached
`timescale 1ns/100ps
module eec_counter_bench;
    localparam int CW_T = 4;
    logic        clk;
    logic        rst;
    logic        countInput;
    logic        resetPinN;
    logic        expWrap = 1'b0;
    logic        scl, sdaPull, sdaOut, sdaOe, wrapFlag;
    int          expCnt = 0;
    int          errors = 0;
    int          compares = 0;
    int          seed = 41;
    // open-drain wire with pull-up
    wire sdaIn = !(sdaPull | (sdaOe & !sdaOut));
    always #2 clk = ~clk;
    eec_counter #(.CW(CW_T)) eec_counter_inst (.clk(clk), .rst(rst),
        .countInput(countInput), .resetPinN(resetPinN), .scl(scl), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .wrapFlag(wrapFlag));
    eec_i2c_master eec_i2c_master_inst (.clk(clk), .sda(sdaIn), .scl(scl),
        .sdaPull(sdaPull));
    task automatic stop_test;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // compare one result, nack in the top bit
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // model: one count, a wrap toggles the flag
    task automatic bump;
        expCnt = (expCnt + 1) % (1 << CW_T);
        if (expCnt == 0)
            expWrap = !expWrap;
    endtask
    // n count pulses, model follows
    task automatic pulse(input int n);
        repeat (n) begin
            countInput = 1'b1;
            eec_i2c_master_inst.tk(8);
            countInput = 1'b0;
            eec_i2c_master_inst.tk(8);
            bump();
        end
    endtask
    // read count plus fill byte and compare
    task automatic rdChk;
        logic [31:0] v;
        logic        na;
        eec_i2c_master_inst.rdCnt(v, na);
        chk({na, v}, {1'b0, expCnt[23:0], 8'hFF});
        chk({32'h0, wrapFlag}, {32'h0, expWrap});
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        stop_test();
    end
    // main sequence
    initial begin
        logic [31:0] v;
        logic        na;
        clk = 1'b0;
        rst = 1'b1;
        countInput = 1'b0;
        resetPinN = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        eec_i2c_master_inst.tk(8);
        rdChk();
        pulse(1 + {$random(seed)} % 20);
        rdChk();
        $display("test count done");
        for (int h = 0; h < 2; h++) begin
            countInput = h[0];
            if (h == 1)
                bump();
            eec_i2c_master_inst.tk(8);
            fork
                eec_i2c_master_inst.rdCnt(v, na);
                repeat (3) begin
                    eec_i2c_master_inst.tk(40);
                    countInput = 1'b0;
                    eec_i2c_master_inst.tk(8);
                    countInput = 1'b1;
                end
            join
            chk({na, v}, {1'b0, expCnt[23:0], 8'hFF});
            if (h == 0)
                bump();
            countInput = 1'b0;
            rdChk();
        end
        $display("test busy edges done");
        pulse(16);
        if (!expWrap)
            pulse(16);
        chk({32'h0, wrapFlag}, {32'h0, expWrap});
        resetPinN = 1'b0;
        pulse(2);
        expCnt = 0;
        expWrap = 1'b0;
        rdChk();
        resetPinN = 1'b1;
        pulse(2);
        rdChk();
        $display("test reset pin done");
        for (int c = 0; c < 8; c++) begin
            pulse(c == 1 ? 17 : 1);
            v = $random(seed);
            eec_i2c_master_inst.wrFree({v[23:3], c[2:0]}, na);
            chk({na, 32'h0}, 33'h0);
            if (c == 2) begin
                expCnt = 0;
                expWrap = 1'b0;
            end
            rdChk();
        end
        chk({32'h0, wrapFlag}, 33'h0);
        $display("test reset command done");
        stop_test();
    end
endmodule // eec_counter_bench
